/* common/dcw_pkg.sv */
// Constants and types for the codec control word block
package dcw_pkg;
    localparam int CW_WIDTH = 16;
    localparam logic [15:0] CW_RESET = 16'h0000;
    localparam int BIT_FORMAT = 0;
    localparam int BIT_WLEN_LO = 1;
    localparam int BIT_WLEN_HI = 2;
    localparam int BIT_OUT_LOW = 3;
    localparam int BIT_DAC1_RST = 4;
    localparam int BIT_DAC2_RST = 5;
    localparam int BIT_PATH_OVR = 6;
    localparam int BIT_PATH_SRC = 7;
    localparam int BIT_ADC_RST = 8;
    localparam int BIT_TEST_LO = 9;
    localparam int BIT_RAND_EN = 12;
    localparam int BIT_LINEAR = 13;
    localparam int BIT_DECIM = 14;
    localparam int BIT_CLR_OFF = 15;
    localparam int WRAM_WORDS = 128;
    localparam int WRAM_DW = 24;
    localparam int WRAM_AW = 7;
    localparam logic [6:0] PTR_A_LIN = 7'h00;
    localparam logic [6:0] PTR_B_LIN = 7'h40;
    localparam int DLY_AW = 12;
    localparam logic [11:0] DLY_BANK2 = 12'h400;
    localparam logic [4:0] CLR_FR_512 = 5'h08;
    localparam logic [4:0] CLR_FR_384 = 5'h0B;
    localparam logic [4:0] CLR_FR_256 = 5'h10;
    localparam logic [1:0] SLAVE_WAIT = 2'h3;
    localparam logic [1:0] MCLK_384 = 2'h0;
    localparam logic [1:0] MCLK_512 = 2'h1;
    localparam logic [1:0] MCLK_256 = 2'h2;
    localparam logic [23:0] LFSR_SEED = 24'h000001;
    localparam logic [23:0] LFSR_TAPS = 24'hDFE253;
    localparam logic [4:0] WLEN_24 = 5'h18;
    localparam logic [4:0] WLEN_20 = 5'h14;
    localparam logic [4:0] WLEN_16 = 5'h10;
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_WAIT = 2'b01,
        ST_CLEAR = 2'b10,
        ST_RUN = 2'b11
    } dcw_state_t;
endpackage

/* test/dcw_control_bench.sv */
// Self-checking bench for the codec control word block
module dcw_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import dcw_pkg::*;
    logic clk = 0, reset = 1, hold_n = 0, go = 0, rude = 0, frise = 0;
    logic dly_hi = 0;
    logic frame_clock = 0, master_mode = 1, sample_tick = 0;
    logic random_fetch_op = 0, dsp_wr = 0, dsp_sel_b = 0;
    logic serial_out_data = 0, adc_data_bit = 0, serial_audio_in_first = 0;
    logic proc_reset_n, conv_reset_n, host_wr, system_reset;
    logic internal_reset_pulse, clear_active, dly_clear_we, adc_hold_reset;
    logic dac_first_hold_reset, analog_out_first_oe, dac_second_hold_reset;
    logic path_data, serial_audio_out, i2s_format;
    logic [1:0] mclk_ratio = 0;
    logic [3:0] fcnt = 0;
    logic [4:0] input_word_bits;
    logic [6:0] dsp_offset = 0, work_pointer_a, work_pointer_b;
    logic [11:0] dly_offset = 0, delay_line_addr;
    logic [15:0] word = 0, host_wdata, codec_control_word;
    logic [23:0] dsp_wdata = 0, work_ram_rdata, internal_data_bus;
    logic [31:0] seed = 95153;
    int fails = 0, n_tests = 0;
    always #10 clk = ~clk;
    dcw_control dut_u (.clk, .reset, .proc_reset_n, .conv_reset_n,
        .frame_clock, .master_mode, .mclk_ratio, .host_wr, .host_wdata,
        .sample_tick, .random_fetch_op, .dsp_wr, .dsp_sel_b, .dsp_offset,
        .dsp_wdata, .dly_offset, .serial_out_data, .adc_data_bit,
        .serial_audio_in_first, .codec_control_word, .system_reset,
        .internal_reset_pulse, .clear_active, .dly_clear_we, .delay_line_addr,
        .work_pointer_a, .work_pointer_b, .work_ram_rdata, .internal_data_bus,
        .adc_hold_reset, .dac_first_hold_reset, .analog_out_first_oe,
        .dac_second_hold_reset, .path_data, .serial_audio_out, .i2s_format,
        .input_word_bits);
    dcw_host_model host_u (.clk, .hold_n, .go, .rude, .word, .proc_reset_n,
        .conv_reset_n, .host_wr, .host_wdata);
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [15:0] san(input logic [15:0] w);
        w = w & 16'hF1FF;
        if (w[0]) w[2:1] = 2'b00;
        return w;
    endfunction
    function automatic logic [4:0] wbits(input logic [1:0] c);
        return c == 2'b10 ? 5'h14 : (c == 2'b11 ? 5'h10 : 5'h18);
    endfunction
    // Clear length in frames for a clock ratio
    function automatic int clr_len(input logic [1:0] r);
        return r == 2'h1 ? 8 : (r == 2'h0 ? 11 : 16);
    endfunction
    // One step of the random shift register
    function automatic logic [23:0] lstep(input logic [23:0] x);
        return {x[22:0], ^(x & LFSR_TAPS)};
    endfunction
    // Frame of 16 cycles, one sample tick each, random data lines
    always @(negedge clk) begin
        seed <= xs(seed);
        fcnt <= fcnt + 4'h1;
        frame_clock <= fcnt[3];
        frise <= fcnt == 4'h8;
        sample_tick <= fcnt == 4'h0;
        {dsp_wr, dsp_sel_b, serial_out_data, adc_data_bit} <= seed[3:0];
        serial_audio_in_first <= seed[4];
        dsp_wdata <= seed[31:8];
        dly_offset <= dly_hi ? (seed[19:8] | 12'h400)
                             : {2'b00, seed[17:8]};
    end
    task automatic chk(input string name, input logic [23:0] exp,
        input logic [23:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] w, input logic bad);
        @(negedge clk);
        word <= w;
        go <= 1;
        rude <= bad;
        @(negedge clk);
        go <= 0;
        repeat (4) @(negedge clk);
    endtask
    // Count frame rises until the pulse, or while the clear lasts
    task automatic rises(input logic pulse, output int n);
        n = 0;
        for (int k = 0; k < 600; k++) begin
            @(posedge clk);
            #1;
            if (pulse ? internal_reset_pulse === 1 : clear_active !== 1) break;
            if (frise) n++;
        end
    endtask
    task automatic run(input logic [1:0] r, input logic m,
        input logic [15:0] e);
        logic [15:0] w;
        logic [6:0] a0;
        logic [11:0] b0;
        logic [23:0] r0;
        logic pe;
        int n;
        w = san(seed[15:0] & 16'h0FFF | e);
        @(negedge clk);
        hold_n <= 0;
        mclk_ratio <= r;
        master_mode <= m;
        random_fetch_op <= e[12];
        dly_hi <= ~dly_hi;
        repeat (4) @(negedge clk);
        wr(w, 0);
        chk("word", w, codec_control_word);
        chk("i2s", w[0], i2s_format);
        // Release just after a frame rise so the next rise finds the wait
        do @(negedge clk); while (fcnt != 4'h9);
        hold_n <= 1;
        rises(1, n);
        chk("to_pulse", m ? 1 : 3, n);
        repeat (2) @(posedge clk);
        chk("clr_we", !w[15], dly_clear_we);
        rises(0, n);
        chk("clear", w[15] ? 0 : clr_len(r), n);
        chk("adc_rst", w[8], adc_hold_reset);
        chk("dac2_rst", w[5], dac_second_hold_reset);
        chk("dac1_oe", !w[4], analog_out_first_oe);
        chk("serial_audio_out", serial_out_data & !w[3], serial_audio_out);
        pe = (w[6] & w[7]) ? serial_audio_in_first : adc_data_bit;
        chk("path", pe, path_data);
        wr(~w, 1);
        chk("refused", w, codec_control_word);
        dsp_offset <= seed[6:0];
        repeat (3) @(negedge clk);
        a0 = work_pointer_a;
        r0 = internal_data_bus;
        b0 = 12'(delay_line_addr - dly_offset);
        repeat (16) @(negedge clk);
        if (w[13]) begin
            chk("ptr_a", dsp_offset, work_pointer_a);
            chk("ptr_b", 7'(dsp_offset + 7'h40), work_pointer_b);
        end else begin
            chk("ring", 7'(a0 + 7'h01), work_pointer_a);
        end
        if (e[12]) chk("random", lstep(r0), internal_data_bus);
        // Two samples later: one slow step in decimation with the offset in bank 2, else two steps
        repeat (16) @(negedge clk);
        n = (w[14] && dly_hi) ? 1 : 2;
        b0 = 12'(b0 - 12'(n));
        chk("dly_step", b0, 12'(delay_line_addr - dly_offset));
    endtask
    task final_report;
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        logic [15:0] v;
        repeat (2) @(posedge clk);
        @(negedge clk);
        reset <= 0;
        repeat (4) @(negedge clk);
        chk("word_reset", 0, codec_control_word);
        chk("bits_reset", 24, input_word_bits);
        for (int i = 0; i < 8; i++) begin
            v = san({seed[15:3], 3'(i)});
            wr(v, 0);
            chk("word_load", v, codec_control_word);
            chk("word_bits", wbits(v[2:1]), input_word_bits);
        end
        run(2'h1, 1, 16'h0000);
        run(2'h0, 1, 16'h0000);
        run(2'h2, 0, 16'h0000);
        run(2'h1, 1, 16'hB000);
        run(2'h2, 1, 16'h4000);
        run(2'h0, 0, 16'h4000);
        final_report;
    end
    initial begin
        #400000;
        fails++;
        final_report;
    end
endmodule

/* test/dcw_control_checker.sv */
// Port-level checks of the codec control word block
module dcw_control_checker
    import dcw_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic proc_reset_n,
    input wire logic conv_reset_n,
    input wire logic random_fetch_op,
    input wire logic [15:0] codec_control_word,
    input wire logic system_reset,
    input wire logic internal_reset_pulse,
    input wire logic clear_active,
    input wire logic [23:0] internal_data_bus,
    input wire logic adc_hold_reset,
    input wire logic dac_first_hold_reset,
    input wire logic analog_out_first_oe,
    input wire logic dac_second_hold_reset,
    input wire logic serial_audio_out,
    input wire logic i2s_format,
    input wire logic [4:0] input_word_bits
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_wlen;
        codec_control_word[2:1] == 2'b11 |=> input_word_bits == WLEN_16;
    endproperty
    a_wlen: assert property (p_wlen)
        else $error("word length wrong");
    property p_wl20;
        codec_control_word[2:1] == 2'b10 |=> input_word_bits == WLEN_20;
    endproperty
    a_wl20: assert property (p_wl20)
        else $error("word length 20 wrong");
    property p_fmt;
        1 |=> i2s_format == $past(codec_control_word[0]);
    endproperty
    a_fmt: assert property (p_fmt)
        else $error("format wrong");
    property p_low;
        codec_control_word[3] |=> !serial_audio_out;
    endproperty
    a_low: assert property (p_low)
        else $error("output not low");
    property p_adc;
        codec_control_word[8] |=> adc_hold_reset;
    endproperty
    a_adc: assert property (p_adc)
        else $error("adc not held");
    property p_dac2;
        codec_control_word[5] |=> dac_second_hold_reset;
    endproperty
    a_dac2: assert property (p_dac2)
        else $error("dac2 not held");
    property p_dac1;
        codec_control_word[4]
            |=> dac_first_hold_reset && !analog_out_first_oe;
    endproperty
    a_dac1: assert property (p_dac1)
        else $error("dac1 not off");
    property p_sys;
        (!proc_reset_n && !conv_reset_n) [*4] |-> system_reset;
    endproperty
    a_sys: assert property (p_sys)
        else $error("no system reset");
    property p_rel;
        proc_reset_n [*4] |-> !system_reset;
    endproperty
    a_rel: assert property (p_rel)
        else $error("reset not released");
    property p_lock;
        (!system_reset) [*2] |-> $stable(codec_control_word);
    endproperty
    a_lock: assert property (p_lock)
        else $error("word changed in run");
    property p_noclr;
        internal_reset_pulse && codec_control_word[15]
            |=> !clear_active [*2];
    endproperty
    a_noclr: assert property (p_noclr)
        else $error("clear not skipped");
    property p_bus;
        !random_fetch_op |=> internal_data_bus == 24'h000000;
    endproperty
    a_bus: assert property (p_bus)
        else $error("bus not idle");
endmodule
bind dcw_control dcw_control_checker chk_u (.clk, .reset, .proc_reset_n,
    .conv_reset_n, .random_fetch_op, .codec_control_word, .system_reset,
    .internal_reset_pulse, .clear_active, .internal_data_bus, .adc_hold_reset,
    .dac_first_hold_reset, .analog_out_first_oe, .dac_second_hold_reset,
    .serial_audio_out, .i2s_format, .input_word_bits);

/* test/dcw_host_model.sv */
// Host controller model that loads the control word during system reset
module dcw_host_model (
    input wire logic clk,
    input wire logic hold_n,
    input wire logic go,
    input wire logic rude,
    input wire logic [15:0] word,
    output logic proc_reset_n,
    output logic conv_reset_n,
    output logic host_wr,
    output logic [15:0] host_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] safe;
    initial {proc_reset_n, conv_reset_n, host_wr, host_wdata} = '0;
    // Test bits stay clear, I2S keeps word length at Mode 1
    always_comb begin
        safe = word & 16'hF1FF;
        if (word[0]) safe[2:1] = 2'b00;
    end
    // Both resets follow hold, writes only while held unless told otherwise
    always @(negedge clk) begin
        proc_reset_n <= hold_n;
        conv_reset_n <= hold_n;
        host_wr <= go && (!hold_n || rude);
        host_wdata <= (go ? safe : ~host_wdata);
    end
endmodule

/* verilog/dcw_control.sv */
// Codec control word register and the sequencing it steers
module dcw_control #(
    parameter int RAM_WORDS = dcw_pkg::WRAM_WORDS
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic proc_reset_n,
    input wire logic conv_reset_n,
    input wire logic frame_clock,
    input wire logic master_mode,
    input wire logic [1:0] mclk_ratio,
    input wire logic host_wr,
    input wire logic [15:0] host_wdata,
    input wire logic sample_tick,
    input wire logic random_fetch_op,
    input wire logic dsp_wr,
    input wire logic dsp_sel_b,
    input wire logic [6:0] dsp_offset,
    input wire logic [23:0] dsp_wdata,
    input wire logic [11:0] dly_offset,
    input wire logic serial_out_data,
    input wire logic adc_data_bit,
    input wire logic serial_audio_in_first,
    output logic [15:0] codec_control_word,
    output logic system_reset,
    output logic internal_reset_pulse,
    output logic clear_active,
    output logic dly_clear_we,
    output logic [11:0] delay_line_addr,
    output logic [6:0] work_pointer_a,
    output logic [6:0] work_pointer_b,
    output logic [23:0] work_ram_rdata,
    output logic [23:0] internal_data_bus,
    output logic adc_hold_reset,
    output logic dac_first_hold_reset,
    output logic analog_out_first_oe,
    output logic dac_second_hold_reset,
    output logic path_data,
    output logic serial_audio_out,
    output logic i2s_format,
    output logic [4:0] input_word_bits
);
    import dcw_pkg::*;

    // Refuse a depth that the seven-bit pointers cannot serve
    if (RAM_WORDS != WRAM_WORDS) begin : g_depth_check
        $error("work RAM depth must be 128");
    end

    // Double-flop of asynchronous pins
    logic [2:0] sy1_reg;
    logic [2:0] sy2_reg;
    logic fr_prev_reg;
    always_ff @(posedge clk) begin
        if (reset) begin
            sy1_reg <= 3'h0;
            sy2_reg <= 3'h0;
            fr_prev_reg <= 1'b0;
        end else begin
            sy1_reg <= {frame_clock, conv_reset_n, proc_reset_n};
            sy2_reg <= sy1_reg;
            fr_prev_reg <= sy2_reg[2];
        end
    end
    logic sys_rst;
    logic fr_rise;
    assign sys_rst = ~sy2_reg[0] & ~sy2_reg[1];
    assign fr_rise = sy2_reg[2] & ~fr_prev_reg;

    // Clear length in frames for the ratio
    function automatic logic [4:0] clr_frames(input logic [1:0] r);
        case (r)
            MCLK_512: clr_frames = CLR_FR_512;
            MCLK_256: clr_frames = CLR_FR_256;
            default: clr_frames = CLR_FR_384;
        endcase
    endfunction

    // Word length decode for the input field
    function automatic logic [4:0] wlen(input logic [1:0] f);
        case (f)
            2'h2: wlen = WLEN_20;
            2'h3: wlen = WLEN_16;
            default: wlen = WLEN_24;
        endcase
    endfunction

    // Control word and sequencer state
    logic [15:0] cw_reg, cw_next;
    dcw_state_t st_reg, st_next;
    logic [4:0] fcnt_reg, fcnt_next;
    logic [6:0] caddr_reg, caddr_next;
    logic [11:0] dcaddr_reg, dcaddr_next;
    logic pulse_reg, pulse_next;
    always_comb begin
        cw_next = cw_reg;
        st_next = st_reg;
        fcnt_next = fcnt_reg;
        caddr_next = caddr_reg;
        dcaddr_next = dcaddr_reg;
        pulse_next = 1'b0;
        if (host_wr && sys_rst) begin
            cw_next = host_wdata;
        end
        case (st_reg)
            ST_RESET: begin
                fcnt_next = 5'h00;
                if (!sys_rst) begin
                    st_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (fr_rise) begin
                    if (master_mode || fcnt_reg == SLAVE_WAIT - 2'h1) begin
                        pulse_next = 1'b1;
                        fcnt_next = 5'h00;
                        caddr_next = 7'h00;
                        dcaddr_next = 12'h000;
                        st_next = cw_reg[BIT_CLR_OFF] ? ST_RUN
                                                      : ST_CLEAR;
                    end else begin
                        fcnt_next = fcnt_reg + 5'h01;
                    end
                end
            end
            ST_CLEAR: begin
                caddr_next = caddr_reg + 7'h01;
                dcaddr_next = dcaddr_reg + 12'h001;
                if (fr_rise) begin
                    fcnt_next = fcnt_reg + 5'h01;
                    if (fcnt_reg + 5'h01 == clr_frames(mclk_ratio)) begin
                        st_next = ST_RUN;
                    end
                end
            end
            ST_RUN: begin
            end
            default: st_next = ST_RESET;
        endcase
        if (sys_rst) begin
            st_next = ST_RESET;
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            cw_reg <= CW_RESET;
            st_reg <= ST_RESET;
            fcnt_reg <= 5'h00;
            caddr_reg <= 7'h00;
            dcaddr_reg <= 12'h000;
            pulse_reg <= 1'b0;
        end else begin
            cw_reg <= cw_next;
            st_reg <= st_next;
            fcnt_reg <= fcnt_next;
            caddr_reg <= caddr_next;
            dcaddr_reg <= dcaddr_next;
            pulse_reg <= pulse_next;
        end
    end

    // Sample-rate pointers and random generator
    logic [6:0] start_reg, start_next;
    logic [11:0] dly_base_reg, dly_base_next;
    logic [11:0] dly_slow_reg, dly_slow_next;
    logic half_reg, half_next;
    logic [23:0] lfsr_reg, lfsr_next;
    logic running;
    assign running = (st_reg == ST_RUN);
    always_comb begin
        start_next = start_reg;
        dly_base_next = dly_base_reg;
        dly_slow_next = dly_slow_reg;
        half_next = half_reg;
        lfsr_next = lfsr_reg;
        if (running && sample_tick) begin
            start_next = start_reg + 7'h01;
            dly_base_next = dly_base_reg - 12'h001;
            half_next = ~half_reg;
            if (half_reg) begin
                dly_slow_next = dly_slow_reg - 12'h001;
            end
            if (cw_reg[BIT_RAND_EN]) begin
                lfsr_next = {lfsr_reg[22:0],
                             ^(lfsr_reg & LFSR_TAPS)};
            end
        end
    end
    always_ff @(posedge clk) begin
        if (reset || sys_rst) begin
            start_reg <= 7'h00;
            dly_base_reg <= 12'h000;
            dly_slow_reg <= 12'h000;
            half_reg <= 1'b0;
            lfsr_reg <= LFSR_SEED;
        end else begin
            start_reg <= start_next;
            dly_base_reg <= dly_base_next;
            dly_slow_reg <= dly_slow_next;
            half_reg <= half_next;
            lfsr_reg <= lfsr_next;
        end
    end

    // Pointer arithmetic for the work RAM and delay RAM
    logic linear;
    logic [6:0] ptr_a, ptr_b, ram_addr;
    logic [11:0] dly_addr;
    logic ram_we;
    logic [23:0] ram_wd, ram_rd;
    assign linear = cw_reg[BIT_LINEAR];
    assign ptr_a = (linear ? PTR_A_LIN : start_reg) + dsp_offset;
    assign ptr_b = (linear ? PTR_B_LIN : start_reg + PTR_B_LIN)
                   + dsp_offset;
    assign ram_addr = clear_active ? caddr_reg
                                   : (dsp_sel_b ? ptr_b : ptr_a);
    assign ram_we = clear_active | (running & dsp_wr);
    assign ram_wd = clear_active ? 24'h000000 : dsp_wdata;
    always_comb begin
        if (cw_reg[BIT_DECIM] && dly_offset >= DLY_BANK2) begin
            dly_addr = dly_slow_reg + dly_offset;
        end else begin
            dly_addr = dly_base_reg + dly_offset;
        end
    end

    dcw_work_ram #(
        .DW(WRAM_DW),
        .AW(WRAM_AW)
    ) u_ram (
        .clk(clk),
        .wr_en(ram_we),
        .addr(ram_addr),
        .wr_data(ram_wd),
        .rd_data(ram_rd)
    );

    // Registered outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            codec_control_word <= CW_RESET;
            system_reset <= 1'b1;
            internal_reset_pulse <= 1'b0;
            clear_active <= 1'b0;
            dly_clear_we <= 1'b0;
            delay_line_addr <= 12'h000;
            work_pointer_a <= 7'h00;
            work_pointer_b <= 7'h00;
            work_ram_rdata <= 24'h000000;
            internal_data_bus <= 24'h000000;
            adc_hold_reset <= 1'b1;
            dac_first_hold_reset <= 1'b1;
            analog_out_first_oe <= 1'b0;
            dac_second_hold_reset <= 1'b1;
            path_data <= 1'b0;
            serial_audio_out <= 1'b0;
            i2s_format <= 1'b0;
            input_word_bits <= WLEN_24;
        end else begin
            codec_control_word <= cw_next;
            system_reset <= sys_rst;
            internal_reset_pulse <= pulse_next;
            clear_active <= (st_next == ST_CLEAR);
            dly_clear_we <= (st_next == ST_CLEAR);
            delay_line_addr <= (st_next == ST_CLEAR) ? dcaddr_next
                                                     : dly_addr;
            work_pointer_a <= ptr_a;
            work_pointer_b <= ptr_b;
            work_ram_rdata <= ram_rd;
            internal_data_bus <= random_fetch_op ? lfsr_reg
                                                 : 24'h000000;
            adc_hold_reset <= sys_rst | cw_reg[BIT_ADC_RST];
            dac_first_hold_reset <= sys_rst | cw_reg[BIT_DAC1_RST];
            analog_out_first_oe <= ~(sys_rst | cw_reg[BIT_DAC1_RST]);
            dac_second_hold_reset <= sys_rst
                                     | cw_reg[BIT_DAC2_RST];
            if (cw_reg[BIT_PATH_OVR]) begin
                path_data <= cw_reg[BIT_PATH_SRC] ? serial_audio_in_first
                                                  : adc_data_bit;
            end else begin
                path_data <= adc_data_bit;
            end
            serial_audio_out <= serial_out_data
                                & ~cw_reg[BIT_OUT_LOW];
            i2s_format <= cw_reg[BIT_FORMAT];
            input_word_bits <= wlen(cw_reg[BIT_WLEN_HI:BIT_WLEN_LO]);
        end
    end
endmodule

/* verilog/dcw_work_ram.sv */
// Work RAM, single port, registered read data
module dcw_work_ram #(
    parameter int DW = 24,
    parameter int AW = 7
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wr_data,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic [DW-1:0] rd_next;

    // Read path
    always_comb begin
        rd_next = mem[addr];
    end

    // Storage and read register
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
        rd_data <= rd_next;
    end
endmodule
